/* hdl/iyb_defines.vh */
// Constants for the Y-indexed bus cycle sequencer
`ifndef IYB_DEFINES_VH
`define IYB_DEFINES_VH
`define IYB_PAGE_PREFIX 8'h18
`define IYB_OP_JUMP 8'h6E
`define IYB_OP_TEST 8'h6D
`define IYB_OP_CALL 8'hAD
`define IYB_DUMMY_ADDR 16'hFFFF
// Instruction classes
`define IYB_CLS_JUMP 4'h0
`define IYB_CLS_ALU8 4'h1
`define IYB_CLS_RMW 4'h2
`define IYB_CLS_TEST 4'h3
`define IYB_CLS_STORE8 4'h4
`define IYB_CLS_LOAD16 4'h5
`define IYB_CLS_STORE16 4'h6
`define IYB_CLS_ARITH16 4'h7
`define IYB_CLS_CALL 4'h8
`define IYB_CLS_BITOP 4'h9
`define IYB_CLS_BRBIT 4'hA
// Cycle counts per class
`define IYB_LEN_JUMP 4'h4
`define IYB_LEN_ALU8 4'h5
`define IYB_LEN_RMW 4'h7
`define IYB_LEN_TEST 4'h7
`define IYB_LEN_STORE8 4'h5
`define IYB_LEN_LOAD16 4'h6
`define IYB_LEN_STORE16 4'h6
`define IYB_LEN_ARITH16 4'h7
`define IYB_LEN_CALL 4'h7
`define IYB_LEN_BITOP 4'h8
`define IYB_LEN_BRBIT 4'h8
`endif

/* hdl/iyb_cycle_len.v */
// Cycle count lookup per instruction class
`default_nettype none
module iyb_cycle_len (
    input wire [3:0] i_cls,
    output reg [3:0] o_len
);
`include "iyb_defines.vh"
    always @* begin
        case (i_cls)
            `IYB_CLS_JUMP: o_len = `IYB_LEN_JUMP;
            `IYB_CLS_ALU8: o_len = `IYB_LEN_ALU8;
            `IYB_CLS_RMW: o_len = `IYB_LEN_RMW;
            `IYB_CLS_TEST: o_len = `IYB_LEN_TEST;
            `IYB_CLS_STORE8: o_len = `IYB_LEN_STORE8;
            `IYB_CLS_LOAD16: o_len = `IYB_LEN_LOAD16;
            `IYB_CLS_STORE16: o_len = `IYB_LEN_STORE16;
            `IYB_CLS_ARITH16: o_len = `IYB_LEN_ARITH16;
            `IYB_CLS_CALL: o_len = `IYB_LEN_CALL;
            `IYB_CLS_BITOP: o_len = `IYB_LEN_BITOP;
            default: o_len = `IYB_LEN_BRBIT;
        endcase
    end
endmodule // iyb_cycle_len
`default_nettype wire

/* hdl/iyb_sequencer.v */
// Bus cycle sequencer for Y-indexed instructions
`default_nettype none
// Notes on behaviour
// - Every instruction starts with prefix byte read
// - Jump: four cycles, ends dummy read
// - Test: seven cycles, operand cycle five, no writes
// - Call: seven cycles, offset then dummy read
// - Call cycle five reads at Y+offset
// - Call cycle six writes return low byte
// - Call cycle seven writes high at SP-1
// - 16-bit loads: high then low byte
// - 16-bit stores: write high then low
// - 16-bit arithmetic: two reads then dummy
// - Address is Y plus unsigned offset; cycle four dummy
// - Read-modify-write: read, dummy, write back
module iyb_sequencer (
    input wire i_sys_clk,
    input wire i_rst_n,
    input wire i_start,
    input wire [3:0] i_cls,
    input wire [15:0] i_opcode_addr,
    input wire [15:0] i_index_y,
    input wire [15:0] i_stack_ptr,
    input wire [15:0] i_return_addr,
    input wire [15:0] i_reg_data,
    input wire [7:0] i_result_data,
    input wire [7:0] i_second_opcode,
    input wire [7:0] i_bus_rdata,
    output reg o_busy,
    output reg o_cycle_valid,
    output reg [3:0] o_cycle_num,
    output reg [15:0] o_addr,
    output reg o_rw,
    output reg [7:0] o_wdata,
    output reg o_done,
    output reg [7:0] o_offset
);
`include "iyb_defines.vh"
////////////////////////////////////////////////////////////////
    // Async assert, synchronous release: no recovery race on release
    reg rst_meta_r;
    reg rst_sync_r;
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
////////////////////////////////////////////////////////////////
    // Two states suffice; the cycle counter carries the rest
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN = 1'b1;
    reg state_r;
    reg [3:0] cls_r;
    reg [3:0] cyc_r;
    reg [15:0] opa_r;
    reg [15:0] iy_r;
    reg [15:0] sp_r;
    reg [15:0] ret_r;
    reg [15:0] rdat_r;
    reg [7:0] res_r;
    reg [7:0] op2_r;
    reg [7:0] off_r;
    // Length table kept apart so a new class touches one place
    wire [3:0] len_w;
    iyb_cycle_len u_len (
        .i_cls(cls_r),
        .o_len(len_w)
    );
    // Offset is zero-extended, never sign-extended
    wire [15:0] eff_w = iy_r + {8'h00, off_r};
    wire [15:0] eff1_w = eff_w + 16'h0001;
    // Offset arrives on the read data during cycle 3
    wire [15:0] eff_now_w = iy_r + {8'h00, i_bus_rdata};
    reg [15:0] addr_nxt;
    reg rw_nxt;
    reg [7:0] wdata_nxt;
    reg [15:0] base_w;
    // Address and direction of bus cycle cyc (1-based)
    always @* begin
        addr_nxt = `IYB_DUMMY_ADDR;
        rw_nxt = 1'b1;
        wdata_nxt = 8'h00;
        base_w = (cyc_r == 4'h4) ? eff_now_w : eff_w;
        case (cyc_r)
            // Prefix shown on write data for observers only, bus still reads
            4'h1: begin
                addr_nxt = opa_r;
                wdata_nxt = `IYB_PAGE_PREFIX;
            end
            4'h2: begin
                addr_nxt = opa_r + 16'h0001;
                wdata_nxt = op2_r;
            end
            4'h3: addr_nxt = opa_r + 16'h0002;
            4'h4: addr_nxt = `IYB_DUMMY_ADDR;
            4'h5: begin
                addr_nxt = base_w;
                if (cls_r == `IYB_CLS_STORE8) begin
                    rw_nxt = 1'b0;
                    wdata_nxt = rdat_r[7:0];
                end else if (cls_r == `IYB_CLS_STORE16) begin
                    rw_nxt = 1'b0;
                    wdata_nxt = rdat_r[15:8];
                end
            end
            4'h6: begin
                if (cls_r == `IYB_CLS_CALL) begin
                    addr_nxt = sp_r;
                    rw_nxt = 1'b0;
                    wdata_nxt = ret_r[7:0];
                end else if (cls_r == `IYB_CLS_LOAD16 || cls_r == `IYB_CLS_ARITH16) begin
                    addr_nxt = eff1_w;
                end else if (cls_r == `IYB_CLS_STORE16) begin
                    addr_nxt = eff1_w;
                    rw_nxt = 1'b0;
                    wdata_nxt = rdat_r[7:0];
                end else if (cls_r == `IYB_CLS_BITOP || cls_r == `IYB_CLS_BRBIT) begin
                    addr_nxt = opa_r + 16'h0003;
                end
            end
            4'h7: begin
                if (cls_r == `IYB_CLS_CALL) begin
                    addr_nxt = sp_r - 16'h0001;
                    rw_nxt = 1'b0;
                    wdata_nxt = ret_r[15:8];
                end else if (cls_r == `IYB_CLS_RMW) begin
                    addr_nxt = eff_w;
                    rw_nxt = 1'b0;
                    wdata_nxt = res_r;
                end else if (cls_r == `IYB_CLS_BRBIT) begin
                    addr_nxt = opa_r + 16'h0004;
                end
            end
            // Branch-on-bit ends on a dummy read, never a write
            4'h8: begin
                if (cls_r == `IYB_CLS_BITOP) begin
                    addr_nxt = eff_w;
                    rw_nxt = 1'b0;
                    wdata_nxt = res_r;
                end
            end
            // Unlisted cycles read the harmless dummy address
            default: addr_nxt = `IYB_DUMMY_ADDR;
        endcase
    end
////////////////////////////////////////////////////////////////
    // Start is ignored while busy; no refusal is signalled
    wire fresh_w = (state_r == ST_IDLE) && i_start;
    always @(posedge i_sys_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            state_r <= ST_IDLE;
            cls_r <= 4'h0;
            cyc_r <= 4'h0;
            opa_r <= 16'h0000;
            iy_r <= 16'h0000;
            sp_r <= 16'h0000;
            ret_r <= 16'h0000;
            rdat_r <= 16'h0000;
            res_r <= 8'h00;
            op2_r <= 8'h00;
            off_r <= 8'h00;
            o_busy <= 1'b0;
            o_cycle_valid <= 1'b0;
            o_cycle_num <= 4'h0;
            o_addr <= `IYB_DUMMY_ADDR;
            o_rw <= 1'b1;
            o_wdata <= 8'h00;
            o_done <= 1'b0;
            o_offset <= 8'h00;
        end else begin
            o_done <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    o_cycle_valid <= 1'b0;
                    o_rw <= 1'b1;
                    if (fresh_w) begin
                        // Operands frozen at take except the result byte; later changes to the other inputs are ignored
                        state_r <= ST_RUN;
                        cls_r <= i_cls;
                        cyc_r <= 4'h1;
                        opa_r <= i_opcode_addr;
                        iy_r <= i_index_y;
                        sp_r <= i_stack_ptr;
                        ret_r <= i_return_addr;
                        rdat_r <= i_reg_data;
                        res_r <= i_result_data;
                        op2_r <= i_second_opcode;
                        o_busy <= 1'b1;
                    end
                end
                default: begin
                    o_cycle_valid <= 1'b1;
                    o_cycle_num <= cyc_r;
                    o_addr <= addr_nxt;
                    o_rw <= rw_nxt;
                    o_wdata <= wdata_nxt;
                    // Result byte may be refreshed until the write cycle
                    res_r <= i_result_data;
                    if (cyc_r == 4'h4) begin
                        off_r <= i_bus_rdata;
                        o_offset <= i_bus_rdata;
                    end
                    // Busy drops with the last cycle, so one idle edge follows
                    if (cyc_r == len_w) begin
                        state_r <= ST_IDLE;
                        cyc_r <= 4'h0;
                        o_busy <= 1'b0;
                        o_done <= 1'b1;
                    end else begin
                        cyc_r <= cyc_r + 4'h1;
                    end
                end
            endcase
        end
    end
endmodule // iyb_sequencer
`default_nettype wire

/* testbench/iyb_mem_model.sv */
// Memory model on the far side of the sequencer bus
`default_nettype none
module iyb_mem_model (
    input wire logic [15:0] i_addr,
    input wire logic i_rw,
    input wire logic i_valid,
    output logic [7:0] o_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:65535];
    // Idle bus shows inverted data so a stale byte never looks valid
    assign o_rdata = (i_valid && i_rw) ? mem[i_addr] : ~mem[i_addr];
endmodule // iyb_mem_model
`default_nettype wire

/* testbench/iyb_seq_checker.sv */
// Port assertions for the Y-indexed sequencer
`default_nettype none
`include "iyb_defines.vh"
module iyb_seq_checker (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic [3:0] i_cls,
    input wire logic [15:0] i_index_y,
    input wire logic [15:0] i_stack_ptr,
    input wire logic [15:0] i_return_addr,
    input wire logic [15:0] i_reg_data,
    input wire logic [7:0] i_result_data,
    input wire logic o_busy,
    input wire logic o_cycle_valid,
    input wire logic [3:0] o_cycle_num,
    input wire logic [15:0] o_addr,
    input wire logic o_rw,
    input wire logic [7:0] o_wdata,
    input wire logic o_done,
    input wire logic [7:0] o_offset
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    wire logic [15:0] opnd = i_index_y + {8'h00, o_offset};
    wire logic c5 = o_cycle_valid && o_cycle_num == 4'h5;
    start_taken_a: assert property (i_start && !o_busy |=> o_busy ##1 (o_cycle_valid && o_cycle_num == 4'h1))
        else $error("start not taken");
    prefix_dummy_a: assert property (o_cycle_valid && o_cycle_num == 4'h1 |-> o_rw && o_wdata == 8'h18 ##1 o_rw
        ##1 o_rw ##1 (o_rw && o_addr == 16'hFFFF)) else $error("bad opening cycles");
    jump_len_a: assert property (o_cycle_valid && o_cycle_num == 4'h4 && i_cls == `IYB_CLS_JUMP
        |-> o_done ##1 !o_cycle_valid) else $error("jump length wrong");
    test_tail_a: assert property (c5 && i_cls == `IYB_CLS_TEST |-> o_rw && o_addr == opnd
        ##1 (o_rw && o_addr == 16'hFFFF)[*2] ##0 o_done) else $error("test tail wrong");
    call_push_a: assert property (c5 && i_cls == `IYB_CLS_CALL |-> o_rw && o_addr == opnd ##1 (!o_rw
        && o_addr == i_stack_ptr && o_wdata == i_return_addr[7:0]) ##1 (!o_rw && o_addr == i_stack_ptr - 16'h1
        && o_wdata == i_return_addr[15:8] && o_done)) else $error("call push wrong");
    store_pair_a: assert property (c5 && i_cls == `IYB_CLS_STORE16 |-> !o_rw && o_wdata == i_reg_data[15:8]
        ##1 (!o_rw && o_addr == opnd + 16'h1 && o_wdata == i_reg_data[7:0] && o_done)) else $error("store pair wrong");
    rmw_write_a: assert property (o_cycle_valid && o_cycle_num == 4'h7 && i_cls == `IYB_CLS_RMW
        |-> !o_rw && o_addr == opnd && o_wdata == i_result_data && o_done) else $error("write back wrong");
    load_pair_a: assert property (c5 && i_cls == `IYB_CLS_LOAD16 |-> o_rw && o_addr == opnd
        ##1 (o_rw && o_addr == opnd + 16'h1 && o_done)) else $error("load pair wrong");
    arith_tail_a: assert property (c5 && i_cls == `IYB_CLS_ARITH16 |-> o_rw && o_addr == opnd
        ##1 (o_rw && o_addr == opnd + 16'h1) ##1 (o_rw && o_addr == 16'hFFFF && o_done))
        else $error("arith tail wrong");
    bit_write_a: assert property (c5 && i_cls == `IYB_CLS_BITOP |-> o_rw && o_addr == opnd ##3 (!o_rw
        && o_addr == opnd && o_wdata == i_result_data && o_done)) else $error("bit write wrong");
    byte_store_a: assert property (c5 && i_cls == `IYB_CLS_STORE8 |-> !o_rw && o_addr == opnd
        && o_wdata == i_reg_data[7:0] && o_done) else $error("byte store wrong");
endmodule // iyb_seq_checker
bind iyb_sequencer iyb_seq_checker iyb_seq_checker_inst (.*);
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the Y-indexed sequencer
`default_nettype none
`include "iyb_defines.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, start = 0, busy, valid, rw, done;
    logic [3:0] cls = 0, num;
    logic [15:0] opa = 0, y = 0, sp = 0, ret = 0, regd = 0, a, addr;
    logic [7:0] res = 0, sec = 0, rdata, wdata, offs;
    int miscompares = 0, cmp_count = 0, cyc = 0;
    logic [15:0] qa[$];
    logic qr[$];
    logic [7:0] qd[$];
    // Cycles 5 on per class, as letters
    string tbl[11] = '{"", "r", "rFw", "rFF", "x", "rs", "hl", "rsF", "rST", "r3Fw", "r34F"};
    always #4 clk = ~clk;
    iyb_sequencer iyb_sequencer_inst (.i_sys_clk(clk), .i_rst_n(rst_n), .i_start(start), .i_cls(cls),
        .i_opcode_addr(opa), .i_index_y(y), .i_stack_ptr(sp), .i_return_addr(ret), .i_reg_data(regd),
        .i_result_data(res), .i_second_opcode(sec), .i_bus_rdata(rdata), .o_busy(busy), .o_cycle_valid(valid),
        .o_cycle_num(num), .o_addr(addr), .o_rw(rw), .o_wdata(wdata), .o_done(done), .o_offset(offs));
    iyb_mem_model iyb_mem_model_inst (.i_addr(addr), .i_rw(rw), .i_valid(valid), .o_rdata(rdata));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (e !== g) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic p(input logic [15:0] ad, input logic r, input logic [7:0] d);
        qa.push_back(ad);
        qr.push_back(r);
        qd.push_back(d);
    endtask
    task automatic run(input logic [3:0] c, input logic [7:0] o);
        int j;
        {opa, y} = $urandom;
        {sp, ret} = $urandom;
        {regd, res, sec} = $urandom;
        cls = c;
        a = y + {8'h00, o};
        iyb_mem_model_inst.mem[opa + 16'h2] = o;
        if (c == `IYB_CLS_JUMP) sec = `IYB_OP_JUMP;
        if (c == `IYB_CLS_TEST) sec = `IYB_OP_TEST;
        if (c == `IYB_CLS_CALL) sec = `IYB_OP_CALL;
        p(opa, 1'b1, `IYB_PAGE_PREFIX);
        p(opa + 16'h1, 1'b1, sec);
        p(opa + 16'h2, 1'b1, 8'h00);
        p(`IYB_DUMMY_ADDR, 1'b1, 8'h00);
        for (int i = 0; i < tbl[c].len(); i++) begin
            case (tbl[c][i])
                "r": p(a, 1'b1, 8'h00);
                "s": p(a + 16'h1, 1'b1, 8'h00);
                "F": p(`IYB_DUMMY_ADDR, 1'b1, 8'h00);
                "w": p(a, 1'b0, res);
                "x": p(a, 1'b0, regd[7:0]);
                "h": p(a, 1'b0, regd[15:8]);
                "l": p(a + 16'h1, 1'b0, regd[7:0]);
                "S": p(sp, 1'b0, ret[7:0]);
                "T": p(sp - 16'h1, 1'b0, ret[15:8]);
                "3": p(opa + 16'h3, 1'b1, 8'h00);
                default: p(opa + 16'h4, 1'b1, 8'h00);
            endcase
        end
        // Start stays high while busy, so refusal is exercised too
        start = 1'b1;
        @(negedge clk);
        chk("taken", 16'h1, {15'h0, busy});
        chk("early", 16'h0, {15'h0, valid});
        for (j = 1; qa.size() > 0; j++) begin
            @(negedge clk);
            if (qa.size() == 1) start = 1'b0;
            chk("cycle", 16'(j), {12'h000, num});
            chk("valid", 16'h1, {15'h0, valid});
            chk("addr", qa.pop_front(), addr);
            chk("done", 16'(qa.size() == 0), {15'h0, done});
            chk("busy", 16'(qa.size() != 0), {15'h0, busy});
            if (!qr[0] || j < 3) chk("wdata", {8'h00, qd[0]}, {8'h00, wdata});
            chk("rw", {15'h0, qr.pop_front()}, {15'h0, rw});
            void'(qd.pop_front());
        end
        @(negedge clk);
        chk("idle", 16'h0, {15'h0, valid});
        chk("idle busy", 16'h0, {15'h0, busy});
        chk("offset", {8'h00, o}, {8'h00, offs});
        $display("test class %h done", c);
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin
            miscompares++;
            results();
        end
    end
    initial begin
        void'($urandom(51823));
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        for (int i = 0; i < 33; i++) run(4'(i % 11), 8'($urandom));
        run(`IYB_CLS_LOAD16, 8'hFF);
        results();
    end
endmodule // tb_top
`default_nettype wire
